// File: inc/acc_pkg.sv
package acc_pkg;

   // ------------------------------------------------------------
   // Register select codes (three-bit field of the command byte)
   // ------------------------------------------------------------
   localparam logic [2:0] RS_STATUS = 3'h0; // Read only: busy flag and channel
   localparam logic [2:0] RS_MODE = 3'h1; // Mode register, carries the mode field
   localparam logic [2:0] RS_SETUP = 3'h2; // Configuration register
   localparam logic [2:0] RS_OFFSET = 3'h6; // Offset coefficient of selected channel
   localparam logic [2:0] RS_FULL = 3'h7; // Full-scale coefficient of selected channel

   // ------------------------------------------------------------
   // Command byte layout
   // ------------------------------------------------------------
   localparam int CMD_READ_BIT = 6; // One selects a read
   localparam int CMD_RS_LSB = 3; // Register select code sits at 5:3
   localparam logic [4:0] CMD_LAST = 5'h07; // Index of last command bit
   localparam logic [4:0] WORD_LAST = 5'h17; // Index of last data bit (24 bits)

   // ------------------------------------------------------------
   // Configuration register fields
   // ------------------------------------------------------------
   localparam logic [23:0] SETUP_RESET = 24'h000117; // Power-on value
   localparam logic [23:0] SETUP_WMASK = 24'h95FFDF; // Reserved bits forced to zero
   localparam int SETUP_CHOP = 23; // Chop enable
   localparam int SETUP_REFERENCE_SOURCE_CHOICE = 20; // Reference source choice
   localparam int SETUP_PSEUDO = 18; // Pseudo-differential inputs
   localparam int SETUP_TEMP = 16; // Temperature sensor
   localparam int SETUP_CH_LSB = 8; // Channel select bits 15:8
   localparam int SETUP_BURN = 7; // Burnout currents
   localparam int SETUP_REFERENCE_DETECT_ENABLE = 6; // Reference detect enable
   localparam int SETUP_BUF = 4; // Input buffer
   localparam int SETUP_POL = 3; // Unipolar when set
   localparam int SETUP_GAIN_LSB = 0; // Gain bits 2:0

   // ------------------------------------------------------------
   // Mode register fields
   // ------------------------------------------------------------
   localparam logic [23:0] MODE_RESET = 24'h000000; // Continuous conversion
   localparam int MODE_MD_LSB = 21; // Operating mode field 23:21
   localparam int STATUS_BUSY = 7; // Calibration busy in status word

   // ------------------------------------------------------------
   // Operating modes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MD_CONT = 3'b000,
      MD_SINGLE = 3'b001,
      MD_IDLE = 3'b010,
      MD_PDOWN = 3'b011,
      MD_ZS_INT = 3'b100,
      MD_FS_INT = 3'b101,
      MD_ZS_SYS = 3'b110,
      MD_FS_SYS = 3'b111
   } acc_mode_t;

   // Serial port states
   typedef enum logic [1:0] {
      SP_CMD = 2'b00,
      SP_WR = 2'b01,
      SP_RD = 2'b10
   } acc_sp_t;

   // Calibration states
   typedef enum logic [0:0] {
      CAL_IDLE = 1'b0,
      CAL_RUN = 1'b1
   } acc_cal_t;

   // Coefficient memory shape
   localparam int COEF_WIDTH = 24;
   localparam int COEF_ADDR_W = 5; // {full-scale flag, channel index}

endpackage : acc_pkg

// File: hdl/acc_coef_mem.sv
// ------------------------------------------------------------
// Per-channel coefficient store, registered read
// ------------------------------------------------------------
module acc_coef_mem #(
   parameter int WIDTH = 24,
   parameter int ADDR_W = 5
) (
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   // Storage array, no reset so it maps to RAM
   logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

   // Write and registered read on one edge
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : acc_coef_mem

// File: hdl/acc_top.sv
// Contract
// RULE_01: Internal zero-scale shorts input, measures offset
// RULE_02: Ready high from calibration start to end
// RULE_03: Any finished calibration leaves converter idle
// RULE_04: Zero-scale result goes to channel offset
// RULE_05: Internal full-scale applies full-scale, stores gain
// RULE_06: Host applies system zero-scale input first
// RULE_07: Host applies system full-scale input first
// RULE_08: Host recalibrates full-scale after gain change
// RULE_09: Host sets clock-divide below 4.75 V
// RULE_10: Host repeats system zero-scale after gain change
// RULE_11: Setup register 24-bit, code 010, 0x000117
// RULE_12: Setup transfers send bit 23 first
// RULE_13: Setup bit map: chop through gain
// RULE_14: Reset: channel 0, buffer, gain ones
// RULE_15: Chop off permits higher conversion rates
// RULE_16: Chop on removes offset continuously
// RULE_17: Idle holds filter, modulator in reset
module acc_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   input wire logic meas_valid,
   input wire logic [23:0] meas_data,
   output logic cal_ready,
   output logic input_short,
   output logic fs_apply,
   output logic filt_mod_reset,
   output logic chop_on,
   output logic fast_rate_allow,
   output logic [23:0] setup_out,
   output logic [2:0] mode_out
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sclk_reg; // Two sync stages plus history for edges
   logic [1:0] cs_n_reg; // Chip select sync
   logic [1:0] din_reg; // Data sync
   logic sclk_rise; // Host samples / we capture here
   logic sclk_fall; // We launch read data here

   // Only stage 1 reads stage 0; edges look at stages 1 and 2
   // Serial clock history resets to its idle high level: no false edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclk_reg <= 3'h7;
         cs_n_reg <= 2'h3;
         din_reg <= 2'h0;
      end else begin
         sclk_reg <= {sclk_reg[1:0], sclk};
         cs_n_reg <= {cs_n_reg[0], cs_n};
         din_reg <= {din_reg[0], din};
      end
   end

   assign sclk_rise = sclk_reg[1] & ~sclk_reg[2];
   assign sclk_fall = ~sclk_reg[1] & sclk_reg[2];

   // ------------------------------------------------------------
   // Register state declarations
   // ------------------------------------------------------------
   logic [23:0] setup_reg, setup_next; // Configuration register
   logic [23:0] mode_reg, mode_next; // Mode register
   acc_pkg::acc_cal_t cal_reg, cal_next; // Calibration engine state
   logic [4:0] cal_addr_reg, cal_addr_next; // Coefficient slot latched at start
   logic [3:0] chan_idx; // Selected channel index
   logic coef_wr; // Coefficient write strobe
   logic [23:0] coef_rd; // Coefficient read data
   logic [4:0] coef_rd_addr; // Read slot for host reads

   // Serial side results
   logic wr_strobe; // One-cycle commit of a written word
   logic [2:0] wr_rs; // Target of that word
   logic [23:0] wr_word; // Word itself

   // ------------------------------------------------------------
   // Serial port
   // ------------------------------------------------------------
   acc_pkg::acc_sp_t sp_reg, sp_next; // Frame phase
   logic [4:0] cnt_reg, cnt_next; // Bit count within phase
   logic [23:0] sh_reg, sh_next; // Shift register
   logic [2:0] rs_reg, rs_next; // Register select of current access
   logic dout_reg, dout_next; // Serial output bit
   logic [7:0] cmd_byte; // Completed command byte
   logic [23:0] rd_word; // Value chosen for a read

   assign cmd_byte = {sh_reg[6:0], din_reg[1]};

   // Read data mux; unmapped codes read zero
   always_comb begin
      case (cmd_byte[acc_pkg::CMD_RS_LSB +: 3])
         acc_pkg::RS_STATUS: begin
            rd_word = {16'h0000, cal_reg == acc_pkg::CAL_RUN, 3'h0, chan_idx};
         end
         acc_pkg::RS_MODE: begin
            rd_word = mode_reg;
         end
         acc_pkg::RS_SETUP: begin
            rd_word = setup_reg; // [RULE_11]
         end
         acc_pkg::RS_OFFSET, acc_pkg::RS_FULL: begin
            rd_word = coef_rd;
         end
         default: begin
            rd_word = 24'h000000;
         end
      endcase
   end

   // Next state of the serial port
   always_comb begin
      sp_next = sp_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      rs_next = rs_reg;
      dout_next = dout_reg;
      wr_strobe = 1'b0;
      wr_rs = rs_reg;
      wr_word = {sh_reg[22:0], din_reg[1]};
      if (cs_n_reg[1]) begin
         // Deselect aborts any half-done frame
         sp_next = acc_pkg::SP_CMD;
         cnt_next = 5'h00;
         dout_next = 1'b0;
      end else begin
         case (sp_reg)
            acc_pkg::SP_CMD: begin
               if (sclk_rise) begin
                  sh_next = {sh_reg[22:0], din_reg[1]};
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == acc_pkg::CMD_LAST) begin
                     cnt_next = 5'h00;
                     rs_next = cmd_byte[acc_pkg::CMD_RS_LSB +: 3];
                     if (cmd_byte[acc_pkg::CMD_READ_BIT]) begin
                        sh_next = rd_word; // Snapshot, bit 23 leaves first [RULE_12]
                        sp_next = acc_pkg::SP_RD;
                     end else begin
                        sp_next = acc_pkg::SP_WR;
                     end
                  end
               end
            end
            acc_pkg::SP_WR: begin
               if (sclk_rise) begin
                  sh_next = {sh_reg[22:0], din_reg[1]}; // MSB arrives first [RULE_12]
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == acc_pkg::WORD_LAST) begin
                     wr_strobe = 1'b1;
                     cnt_next = 5'h00;
                     sp_next = acc_pkg::SP_CMD;
                  end
               end
            end
            acc_pkg::SP_RD: begin
               if (sclk_fall) begin
                  dout_next = sh_reg[23]; // Descending order out [RULE_12]
                  sh_next = {sh_reg[22:0], 1'b0};
               end
               if (sclk_rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg == acc_pkg::WORD_LAST) begin
                     cnt_next = 5'h00;
                     sp_next = acc_pkg::SP_CMD;
                  end
               end
            end
            default: begin
               sp_next = acc_pkg::SP_CMD;
               cnt_next = 5'h00;
            end
         endcase
      end
   end

   // Serial port registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sp_reg <= acc_pkg::SP_CMD;
         cnt_reg <= 5'h00;
         sh_reg <= 24'h000000;
         rs_reg <= 3'h0;
         dout_reg <= 1'b0;
      end else begin
         sp_reg <= sp_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         rs_reg <= rs_next;
         dout_reg <= dout_next;
      end
   end

   // ------------------------------------------------------------
   // Channel decode
   // ------------------------------------------------------------
   // Pseudo mode: upper nibble names the positive input of 16.
   // Otherwise the lowest set channel bit wins; none set means 0.
   always_comb begin
      chan_idx = 4'h0;
      if (setup_reg[acc_pkg::SETUP_PSEUDO]) begin
         chan_idx = setup_reg[acc_pkg::SETUP_CH_LSB + 4 +: 4];
      end else begin
         for (int i = 7; i >= 0; i--) begin
            if (setup_reg[acc_pkg::SETUP_CH_LSB + i]) begin
               chan_idx = i[3:0];
            end
         end
      end
   end

   // Host reads the slot of the current channel
   assign coef_rd_addr = {cmd_byte[acc_pkg::CMD_RS_LSB], chan_idx};

   // ------------------------------------------------------------
   // Registers and calibration engine
   // ------------------------------------------------------------
   logic [2:0] md; // Current operating mode field
   logic [2:0] wr_md; // Mode field of a word being written

   assign md = mode_reg[acc_pkg::MODE_MD_LSB +: 3];
   assign wr_md = wr_word[acc_pkg::MODE_MD_LSB +: 3];

   // Next values of setup, mode and calibration state
   always_comb begin
      setup_next = setup_reg;
      mode_next = mode_reg;
      cal_next = cal_reg;
      cal_addr_next = cal_addr_reg;
      coef_wr = 1'b0;
      if (wr_strobe && wr_rs == acc_pkg::RS_SETUP) begin
         setup_next = wr_word & acc_pkg::SETUP_WMASK; // Reserved stay zero [RULE_13]
      end
      case (cal_reg)
         acc_pkg::CAL_IDLE: begin
            if (wr_strobe && wr_rs == acc_pkg::RS_MODE) begin
               mode_next = wr_word;
               if (wr_md[2]) begin
                  // Slot: bit 0 of the code separates gain from offset [RULE_04] [RULE_05]
                  cal_next = acc_pkg::CAL_RUN; // [RULE_02]
                  cal_addr_next = {wr_md[0], chan_idx};
               end
            end
         end
         acc_pkg::CAL_RUN: begin
            // Mode writes are ignored while a calibration runs
            if (meas_valid) begin
               coef_wr = 1'b1; // Offset or gain to channel slot [RULE_04] [RULE_05]
               cal_next = acc_pkg::CAL_IDLE; // [RULE_02]
               mode_next[acc_pkg::MODE_MD_LSB +: 3] = acc_pkg::MD_IDLE; // [RULE_03]
            end
         end
         default: begin
            cal_next = acc_pkg::CAL_IDLE;
         end
      endcase
   end

   // Register state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         setup_reg <= acc_pkg::SETUP_RESET; // [RULE_11] [RULE_14]
         mode_reg <= acc_pkg::MODE_RESET;
         cal_reg <= acc_pkg::CAL_IDLE;
         cal_addr_reg <= 5'h00;
      end else begin
         setup_reg <= setup_next;
         mode_reg <= mode_next;
         cal_reg <= cal_next;
         cal_addr_reg <= cal_addr_next;
      end
   end

   // ------------------------------------------------------------
   // Coefficient memory
   // ------------------------------------------------------------
   acc_coef_mem #(
      .WIDTH(acc_pkg::COEF_WIDTH),
      .ADDR_W(acc_pkg::COEF_ADDR_W)
   ) u_coef (
      .mclk(mclk),
      .wr_en(coef_wr),
      .wr_addr(cal_addr_reg),
      .wr_data(meas_data),
      .rd_addr(coef_rd_addr),
      .rd_data(coef_rd)
   );

   // ------------------------------------------------------------
   // Analog control outputs
   // ------------------------------------------------------------
   logic ready_next; // Calibration in progress
   logic short_next; // Internal short on the input
   logic fsap_next; // Internal full-scale on the input
   logic fmr_next; // Filter and modulator reset
   logic [2:0] md_next_field; // Mode field after this cycle

   assign md_next_field = mode_next[acc_pkg::MODE_MD_LSB +: 3];

   // Derived from next state so the pins move with the state
   always_comb begin
      ready_next = (cal_next == acc_pkg::CAL_RUN); // [RULE_02]
      short_next = ready_next && md_next_field == acc_pkg::MD_ZS_INT; // [RULE_01]
      fsap_next = ready_next && md_next_field == acc_pkg::MD_FS_INT; // [RULE_05]
      fmr_next = (md_next_field == acc_pkg::MD_IDLE); // Clocks keep running [RULE_17]
   end

   // Output flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cal_ready <= 1'b0;
         input_short <= 1'b0;
         fs_apply <= 1'b0;
         filt_mod_reset <= 1'b0;
         chop_on <= 1'b0;
         fast_rate_allow <= 1'b1;
         setup_out <= acc_pkg::SETUP_RESET;
         mode_out <= acc_pkg::MD_CONT;
      end else begin
         cal_ready <= ready_next;
         input_short <= short_next;
         fs_apply <= fsap_next;
         filt_mod_reset <= fmr_next;
         chop_on <= setup_next[acc_pkg::SETUP_CHOP]; // [RULE_16]
         fast_rate_allow <= ~setup_next[acc_pkg::SETUP_CHOP]; // [RULE_15]
         setup_out <= setup_next;
         mode_out <= md_next_field;
      end
   end

   assign dout = dout_reg;

   // Mode field kept visible for the converter core
   logic unused_md; // Current mode feeds nothing else; mode_out takes the next mode field
   assign unused_md = ^md;

endmodule : acc_top

// File: bench/acc_host_model.sv
// ------------------------------------------------------------
// Host side of the four-wire link
// ------------------------------------------------------------
module acc_host_model (
   input wire logic mclk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout
);
   timeunit 1ns;
   timeprecision 100ps;

   // Link idles with clock high and device deselected
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // Half of the 160 ns link period, just after an mclk edge
   task automatic half_bit();
      repeat (8) @(posedge mclk);
      #1;
   endtask : half_bit

   // Command byte then data bits; short nbits aborts the frame
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdata, input int nbits,
                       output logic [23:0] rdata);
      logic [31:0] word;
      word = {cmd, wdata};
      rdata = 24'h000000;
      cs_n = 1'b0;
      half_bit();
      for (int i = 31; i >= 32 - nbits; i--) begin
         sclk = 1'b0;
         din = word[i];
         half_bit();
         // Device shifted its bit out on the falling edge
         if (i < 24) begin
            rdata[i] = dout;
         end
         sclk = 1'b1;
         half_bit();
      end
      cs_n = 1'b1;
      // Released line must not keep showing the last bit
      din = ~din;
      // Idle gap: without it a back-to-back call hides the deselect
      half_bit();
   endtask : xfer
endmodule : acc_host_model

// File: bench/acc_top_chk.sv
// ------------------------------------------------------------
// Port-level checks of calibration and setup outputs
// ------------------------------------------------------------
module acc_top_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic meas_valid,
   input wire logic [23:0] meas_data,
   input wire logic cal_ready,
   input wire logic input_short,
   input wire logic fs_apply,
   input wire logic filt_mod_reset,
   input wire logic chop_on,
   input wire logic fast_rate_allow,
   input wire logic [23:0] setup_out,
   input wire logic [2:0] mode_out
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Measurement arrives while calibrating
   sequence cal_finish;
      cal_ready && meas_valid;
   endsequence
   // Converter parked in idle with nothing applied
   sequence idle_entered;
      !cal_ready && !input_short && !fs_apply && mode_out == 3'h2 && filt_mod_reset;
   endsequence

   AST_APPLY_SEL: assert property (cal_ready |-> input_short == (mode_out == 3'h4)
      && fs_apply == (mode_out == 3'h5)) else $error("wrong input applied");
   AST_APPLY_OFF: assert property (!cal_ready |-> !input_short && !fs_apply)
      else $error("input applied outside calibration");
   AST_READY_CODE: assert property (cal_ready |-> mode_out[2])
      else $error("ready without calibration code");
   AST_READY_HOLD: assert property (cal_ready && !meas_valid |=> cal_ready)
      else $error("ready dropped early");
   AST_READY_START: assert property ($changed(mode_out) && mode_out[2] |-> ##[0:2] cal_ready)
      else $error("ready not raised");
   AST_CAL_IDLE: assert property (cal_finish |=> idle_entered)
      else $error("no idle after calibration");
   AST_IDLE_RESET: assert property ($stable(mode_out) |-> filt_mod_reset == (mode_out == 3'h2))
      else $error("filter reset mismatch");
   AST_CHOP: assert property ($stable(setup_out) |-> chop_on == setup_out[23]
      && fast_rate_allow == !setup_out[23]) else $error("chop outputs mismatch");
   AST_RESERVED: assert property ((setup_out & 24'h6A0020) == 24'h000000)
      else $error("reserved setup bit set");
   AST_RESET_VAL: assert property ($fell(rst) |-> setup_out == 24'h000117)
      else $error("setup reset value");
endmodule : acc_top_chk

bind acc_top acc_top_chk chk_u (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
   .dout(dout), .meas_valid(meas_valid), .meas_data(meas_data), .cal_ready(cal_ready),
   .input_short(input_short), .fs_apply(fs_apply), .filt_mod_reset(filt_mod_reset),
   .chop_on(chop_on), .fast_rate_allow(fast_rate_allow), .setup_out(setup_out), .mode_out(mode_out));

// File: bench/tb.sv
// ------------------------------------------------------------
// Self-checking bench for calibration control
// ------------------------------------------------------------
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk = 1'b0; // 100 MHz system clock
   logic rst = 1'b1;
   logic sclk, cs_n, din, dout;
   logic meas_valid = 1'b0; // Converter core strobe
   logic [23:0] meas_data = 24'h000000;
   logic cal_ready, input_short, fs_apply, filt_mod_reset, chop_on, fast_rate_allow;
   logic [23:0] setup_out, rd;
   logic [2:0] mode_out;
   int bad_count = 0;
   int check_count = 0;

   always #5 mclk = ~mclk;

   acc_top dut_u (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .meas_valid(meas_valid), .meas_data(meas_data), .cal_ready(cal_ready),
      .input_short(input_short), .fs_apply(fs_apply), .filt_mod_reset(filt_mod_reset),
      .chop_on(chop_on), .fast_rate_allow(fast_rate_allow), .setup_out(setup_out),
      .mode_out(mode_out));
   acc_host_model host_u (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

   // ------------------------------------------------------------
   // Compare, access and closing tasks
   // ------------------------------------------------------------
   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({23'h0, got}, {23'h0, exp}, what);
   endtask : chk_bit

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   // Write: read flag clear, select code in bits 5:3
   task automatic wr(input logic [2:0] rs, input logic [23:0] data);
      host_u.xfer({2'b00, rs, 3'b000}, data, 32, rd);
   endtask : wr

   task automatic rd_chk(input logic [2:0] rs, input logic [23:0] exp);
      host_u.xfer({2'b01, rs, 3'b000}, 24'h000000, 32, rd);
      chk_word(rd, exp, "serial read");
   endtask : rd_chk

   // Bounded wait; a hang ends the run as a failure
   task automatic wait_ready();
      int n;
      n = 0;
      while (cal_ready !== 1'b1 && n < 100) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 100) begin
         bad_count++;
         $display("mismatch at %0t: ready wait timed out", $time);
         end_of_test();
      end
   endtask : wait_ready

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk_word(setup_out, 24'h000117, "setup reset");
      chk_bit(chop_on, 1'b0, "chop reset");
      chk_bit(fast_rate_allow, 1'b1, "rate reset");
      rd_chk(acc_pkg::RS_SETUP, 24'h000117);
      rd_chk(3'h3, 24'h000000); // Unmapped code reads zero
      wr(acc_pkg::RS_SETUP, 24'hFFFFFF);
      chk_word(setup_out, 24'h95FFDF, "setup all ones");
      chk_bit(chop_on, 1'b1, "chop on");
      chk_bit(fast_rate_allow, 1'b0, "rate with chop");
      rd_chk(acc_pkg::RS_SETUP, 24'h95FFDF);
      // Aborted write must leave the register alone
      host_u.xfer(8'h10, 24'h000000, 16, rd);
      chk_word(setup_out, 24'h95FFDF, "aborted write");
      // New gain and channel 3, chop off, then recalibrate
      wr(acc_pkg::RS_SETUP, 24'h000816);
      chk_bit(fast_rate_allow, 1'b1, "rate chop off");
      for (int c = 4; c < 8; c++) begin
         // Host has applied the zero- or full-scale input first
         meas_data = 24'h5A3C00 | 24'(c);
         // Bench supply taken at or above 4.75 V, so clock-divide stays clear
         wr(acc_pkg::RS_MODE, {c[2:0], 21'h0});
         wait_ready();
         chk_bit(input_short, c == 4, "short");
         chk_bit(fs_apply, c == 5, "fs apply");
         // Mode change is refused while calibrating
         if (c == 4) begin
            wr(acc_pkg::RS_MODE, 24'h000000);
            chk_bit(cal_ready, 1'b1, "ready held");
         end
         meas_valid = 1'b1;
         @(posedge mclk);
         #1;
         meas_valid = 1'b0;
         chk_bit(cal_ready, 1'b0, "ready end");
         chk_word({21'h0, mode_out}, 24'h000002, "idle after cal");
         chk_bit(filt_mod_reset, 1'b1, "filter reset");
         rd_chk(c[0] ? acc_pkg::RS_FULL : acc_pkg::RS_OFFSET, meas_data);
      end
      end_of_test();
   end
endmodule : tb
